// ===== core/hb_pkg.sv
// Purpose: Shared constants and types for the half-bridge gate control block
// Assumes: 20 MHz system clock, registers on Avalon-MM with byte addresses
// Notes:   Times are kept in their own unit; the release cycle count is derived here, dead-time cycles in the gate control
package hb_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ             = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS      = 1_000_000_000 / CLK_HZ;
    localparam int unsigned CLK_PERIOD_PS      = CLK_PERIOD_NS * 1000;
    localparam int unsigned DT_BASE_PS         = 32_000;
    localparam int unsigned DT_SLOPE_PS_PER_K  = 440;
    localparam int unsigned DT_OPEN_PS         = 250_000;
    localparam int unsigned DT_RES_MAX_KOHM    = 99;
    localparam int unsigned FAULT_RELEASE_US   = 100;
    localparam int unsigned FAULT_RELEASE_CYC  = FAULT_RELEASE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned DT_CNT_W           = 8;
    localparam int unsigned REL_CNT_W          = 12;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_DT_CFG     = 5'h00;
    localparam logic [4:0] ADDR_STATUS     = 5'h04;
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h08;
    localparam logic [4:0] ADDR_IRQ_MASK   = 5'h0C;
    localparam logic [4:0] ADDR_DT_CYCLES  = 5'h10;

    localparam int unsigned DT_MODE_LSB    = 0;
    localparam int unsigned DT_RES_LSB     = 8;
    localparam int unsigned IRQ_W          = 3;
    localparam int unsigned IRQ_FAULT_SET  = 0;
    localparam int unsigned IRQ_FAULT_REL  = 1;
    localparam int unsigned IRQ_THERMAL    = 2;

    typedef enum logic [1:0]
    {
        DT_MODE_RESISTOR = 2'h0,
        DT_MODE_SHORTED  = 2'h1,
        DT_MODE_OPEN     = 2'h2
    } deadtime_set_type;

    localparam deadtime_set_type DT_MODE_RESET = DT_MODE_OPEN;
    localparam logic [6:0]       DT_RES_RESET  = 7'h00;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Pin flags, in the order they pass the synchroniser
    // ------------------------------------------------------------------
    localparam int unsigned PIN_W = 9;

    typedef struct packed
    {
        logic pwm_above_high;   // Input above high-side turn-on threshold
        logic pwm_below_low;    // Input below low-side turn-on threshold
        logic enable;           // Enable pin high
        logic supply_lockout;   // Main supply under or over window
        logic high_uv;          // High-side floating supply undervoltage
        logic low_uv;           // Low-side floating supply undervoltage
        logic thermal;          // Thermal shutdown comparator
        logic high_vgs_low;     // High-side MOSFET gate-source is low
        logic low_vgs_low;      // Low-side MOSFET gate-source is low
    } pin_in_type;

    typedef struct packed
    {
        logic       read;
        logic       write;
        logic [4:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } avs_req_type;

endpackage

// ===== core/pin_sync.sv
// Purpose: Two-flop synchroniser for a vector of asynchronous pin flags
// Assumes: Each bit is an independent level
// Notes:   First stage is read only by the second stage
module pin_sync
#(
    parameter int unsigned WIDTH = 1
)
(
    input  wire logic             SYS_CLK,  // System clock
    input  wire logic             RST_N,    // Synchronous reset, active low
    input  wire logic [WIDTH-1:0] ASYNC_IN, // Raw pin levels
    output logic      [WIDTH-1:0] SYNC_OUT  // Synchronised levels
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= ASYNC_IN;
            sync_ff <= meta_ff;
        end
    end

    assign SYNC_OUT = sync_ff;

endmodule

// ===== core/half_bridge_gate_control.sv
// Purpose: Gate command, dead-time, interlock and fault flag of a half-bridge driver
// Assumes: Analog comparators arrive as asynchronous flags; registers on Avalon-MM
// Notes:   Gate outputs turn off one cycle after the synchronised inputs settle, and turn on only after the dead-time count
module half_bridge_gate_control
(
    input  wire logic              SYS_CLK,           // System clock, 20 MHz
    input  wire logic              RST_N,             // Synchronous reset, active low
    input  wire hb_pkg::pin_in_type PIN_IN,           // Raw comparator and pin flags
    output logic                   HIGH_GATE_OUT,     // High-side gate command
    output logic                   LOW_GATE_OUT,      // Low-side gate command
    output logic                   FAULT_N_OUT,       // Fault pin output level
    output logic                   FAULT_N_OE_N,      // Fault pin enable, low drives pin
    output logic                   IRQ,               // Level interrupt
    input  wire logic [4:0]        AVS_ADDRESS,       // Byte address
    input  wire logic              AVS_READ,          // Read strobe
    input  wire logic              AVS_WRITE,         // Write strobe
    input  wire logic [3:0]        AVS_BYTEENABLE,    // Byte lanes
    input  wire logic [31:0]       AVS_WRITEDATA,     // Write data
    output logic [31:0]            AVS_READDATA,      // Read data
    output logic                   AVS_WAITREQUEST    // Stall
);
    import hb_pkg::*;

    // ------------------------------------------------------------------
    // Types and signals
    // ------------------------------------------------------------------
    typedef enum logic [4:0]
    {
        ST_OFF     = 5'b00001,
        ST_DT_HIGH = 5'b00010,
        ST_HIGH_ON = 5'b00100,
        ST_DT_LOW  = 5'b01000,
        ST_LOW_ON  = 5'b10000
    } gate_state_type;

    pin_in_type            pin_sync_w;
    avs_req_type           req;
    gate_state_type        state_ff;
    gate_state_type        nxt_state;
    logic [DT_CNT_W-1:0]   dt_cnt_ff;
    logic [DT_CNT_W-1:0]   nxt_dt_cnt;
    logic [DT_CNT_W-1:0]   dt_load;
    logic                  high_gate_ff;
    logic                  low_gate_ff;
    logic                  fault_ff;
    logic [REL_CNT_W-1:0]  rel_cnt_ff;
    logic                  fault_now;
    logic                  gate_block;
    logic                  want_high;
    logic                  want_low;
    deadtime_set_type      dt_mode_ff;
    logic [6:0]            dt_res_ff;
    logic [IRQ_W-1:0]      irq_status_ff;
    logic [IRQ_W-1:0]      irq_mask_ff;
    logic [IRQ_W-1:0]      irq_event;
    logic                  thermal_d_ff;
    logic                  ack_ff;
    logic [31:0]           rdata_ff;
    logic                  irq_ff;
    logic                  wr_take;

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    pin_sync
    #(
        .WIDTH (PIN_W)
    )
    u_pin_sync
    (
        .SYS_CLK  (SYS_CLK),
        .RST_N    (RST_N),
        .ASYNC_IN (PIN_IN),
        .SYNC_OUT (pin_sync_w)
    );

    // ------------------------------------------------------------------
    // Dead-time from setting
    // ------------------------------------------------------------------
    function automatic logic [DT_CNT_W-1:0] dt_cycles(input deadtime_set_type mode, input logic [6:0] res_k);
        int unsigned ps;
        int unsigned k;
        ps = DT_BASE_PS;
        k  = (int'(res_k) > DT_RES_MAX_KOHM) ? DT_RES_MAX_KOHM : int'(res_k);
        case (mode)
            DT_MODE_SHORTED:  ps = DT_BASE_PS;
            DT_MODE_OPEN:     ps = DT_OPEN_PS;
            default:          ps = k * DT_SLOPE_PS_PER_K + DT_BASE_PS;
        endcase
        // Round up so the gap is never shorter than programmed
        dt_cycles = DT_CNT_W'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    endfunction

    assign dt_load = dt_cycles(dt_mode_ff, dt_res_ff);

    // ------------------------------------------------------------------
    // Drive conditions
    // ------------------------------------------------------------------
    assign gate_block = !pin_sync_w.enable || pin_sync_w.supply_lockout || pin_sync_w.thermal;

    // Middle band: neither threshold crossed, so no side is wanted
    assign want_high = !gate_block && pin_sync_w.pwm_above_high && !pin_sync_w.high_uv;
    assign want_low  = !gate_block && pin_sync_w.pwm_below_low && !pin_sync_w.pwm_above_high
                       && !pin_sync_w.low_uv;

    // ------------------------------------------------------------------
    // Gate state machine
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_state  = state_ff;
        nxt_dt_cnt = dt_cnt_ff;
        case (state_ff)
            ST_OFF:
            begin
                if (want_high)
                begin
                    nxt_state  = ST_DT_HIGH;
                    nxt_dt_cnt = dt_load;
                end
                else if (want_low)
                begin
                    nxt_state  = ST_DT_LOW;
                    nxt_dt_cnt = dt_load;
                end
            end
            ST_DT_HIGH:
            begin
                if (!want_high)
                begin
                    nxt_state  = ST_OFF;
                    nxt_dt_cnt = '0;
                end
                else if (dt_cnt_ff != '0)
                begin
                    nxt_dt_cnt = dt_cnt_ff - 1'b1;
                end
                else if (pin_sync_w.low_vgs_low && !low_gate_ff)
                begin
                    nxt_state = ST_HIGH_ON;
                end
            end
            ST_HIGH_ON:
            begin
                if (!want_high)
                begin
                    nxt_state = ST_OFF;
                end
            end
            ST_DT_LOW:
            begin
                if (!want_low)
                begin
                    nxt_state  = ST_OFF;
                    nxt_dt_cnt = '0;
                end
                else if (dt_cnt_ff != '0)
                begin
                    nxt_dt_cnt = dt_cnt_ff - 1'b1;
                end
                else if (pin_sync_w.high_vgs_low && !high_gate_ff)
                begin
                    nxt_state = ST_LOW_ON;
                end
            end
            ST_LOW_ON:
            begin
                if (!want_low)
                begin
                    nxt_state = ST_OFF;
                end
            end
            default:
            begin
                nxt_state  = ST_OFF;
                nxt_dt_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            state_ff  <= ST_OFF;
            dt_cnt_ff <= '0;
        end
        else
        begin
            state_ff  <= nxt_state;
            dt_cnt_ff <= nxt_dt_cnt;
        end
    end

    // Gate outputs, registered from the next state
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            high_gate_ff <= 1'b0;
            low_gate_ff  <= 1'b0;
        end
        else
        begin
            high_gate_ff <= (nxt_state == ST_HIGH_ON);
            low_gate_ff  <= (nxt_state == ST_LOW_ON);
        end
    end

    assign HIGH_GATE_OUT = high_gate_ff;
    assign LOW_GATE_OUT  = low_gate_ff;

    // ------------------------------------------------------------------
    // Fault flag and release delay
    // ------------------------------------------------------------------
    assign fault_now = pin_sync_w.supply_lockout || pin_sync_w.high_uv || pin_sync_w.low_uv
                       || pin_sync_w.thermal;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            fault_ff   <= 1'b1;
            rel_cnt_ff <= '0;
        end
        else if (fault_now)
        begin
            fault_ff   <= 1'b1;
            rel_cnt_ff <= '0;
        end
        else if (fault_ff)
        begin
            if (rel_cnt_ff == REL_CNT_W'(FAULT_RELEASE_CYC - 1))
            begin
                fault_ff   <= 1'b0;
                rel_cnt_ff <= '0;
            end
            else
            begin
                rel_cnt_ff <= rel_cnt_ff + 1'b1;
            end
        end
    end

    // Open drain: pin level fixed low, only the enable moves
    assign FAULT_N_OUT  = 1'b0;
    assign FAULT_N_OE_N = !fault_ff;

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            thermal_d_ff <= 1'b0;
        end
        else
        begin
            thermal_d_ff <= pin_sync_w.thermal;
        end
    end

    always_comb
    begin
        irq_event                = '0;
        irq_event[IRQ_FAULT_SET] = fault_now && !fault_ff;
        irq_event[IRQ_FAULT_REL] = !fault_now && fault_ff && (rel_cnt_ff == REL_CNT_W'(FAULT_RELEASE_CYC - 1));
        irq_event[IRQ_THERMAL]   = pin_sync_w.thermal && !thermal_d_ff;
    end

    // Set beats a same-cycle write-one clear
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            irq_status_ff <= '0;
        end
        else if (wr_take && req.address == ADDR_IRQ_STATUS && req.byteenable[0])
        begin
            irq_status_ff <= (irq_status_ff & ~req.writedata[IRQ_W-1:0]) | irq_event;
        end
        else
        begin
            irq_status_ff <= irq_status_ff | irq_event;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    assign IRQ = irq_ff;

    // ------------------------------------------------------------------
    // Avalon-MM slave, one wait cycle per access
    // ------------------------------------------------------------------
    assign req.read       = AVS_READ;
    assign req.write      = AVS_WRITE;
    assign req.address    = AVS_ADDRESS;
    assign req.byteenable = AVS_BYTEENABLE;
    assign req.writedata  = AVS_WRITEDATA;

    assign AVS_WAITREQUEST = (req.read || req.write) && !ack_ff;
    assign wr_take         = req.write && ack_ff;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            ack_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= (req.read || req.write) && !ack_ff;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            dt_mode_ff  <= DT_MODE_RESET;
            dt_res_ff   <= DT_RES_RESET;
            irq_mask_ff <= IRQ_MASK_RESET;
        end
        else if (wr_take)
        begin
            if (req.address == ADDR_DT_CFG)
            begin
                if (req.byteenable[0])
                begin
                    dt_mode_ff <= deadtime_set_type'(req.writedata[DT_MODE_LSB +: 2]);
                end
                if (req.byteenable[1])
                begin
                    dt_res_ff <= req.writedata[DT_RES_LSB +: 7];
                end
            end
            else if (req.address == ADDR_IRQ_MASK && req.byteenable[0])
            begin
                irq_mask_ff <= req.writedata[IRQ_W-1:0];
            end
        end
    end

    // Read data captured in the wait cycle, stands while waitrequest is low
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            rdata_ff <= '0;
        end
        else if (req.read && !ack_ff)
        begin
            if (req.address == ADDR_DT_CFG)
            begin
                rdata_ff <= {17'h00000, dt_res_ff, 6'h00, dt_mode_ff};
            end
            else if (req.address == ADDR_STATUS)
            begin
                rdata_ff <= {15'h0000, state_ff, pin_sync_w, low_gate_ff, high_gate_ff, fault_ff};
            end
            else if (req.address == ADDR_IRQ_STATUS)
            begin
                rdata_ff <= {29'h00000000, irq_status_ff};
            end
            else if (req.address == ADDR_IRQ_MASK)
            begin
                rdata_ff <= {29'h00000000, irq_mask_ff};
            end
            else if (req.address == ADDR_DT_CYCLES)
            begin
                rdata_ff <= {24'h000000, dt_load};
            end
            else
            begin
                rdata_ff <= 32'h00000000;
            end
        end
    end

    assign AVS_READDATA = rdata_ff;

endmodule

// ===== verif/hb_properties.sv
// Purpose: Port checks of the gate control block
// Assumes: Raw flags act on the gates three edges later
// Notes:   Bound to the top module
module hb_properties
(
    input wire logic               SYS_CLK,        // Clock
    input wire logic               RST_N,          // Reset
    input wire hb_pkg::pin_in_type PIN_IN,         // Raw flags
    input wire logic               HIGH_GATE_OUT,  // High gate
    input wire logic               LOW_GATE_OUT,   // Low gate
    input wire logic               FAULT_N_OUT,    // Fault level
    input wire logic               FAULT_N_OE_N    // Fault enable
);
    timeunit 1ns;
    timeprecision 1ps;
    import hb_pkg::*;
    // ----------
    // Helpers
    // ----------
    logic [11:0] quiet_ff;
    logic        fault_n_out;
    logic        off;
    assign fault_n_out = PIN_IN.supply_lockout | PIN_IN.high_uv | PIN_IN.low_uv | PIN_IN.thermal;
    assign off = !HIGH_GATE_OUT && !LOW_GATE_OUT;
    // Cycles since the last raw fault
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N || fault_n_out)
            quiet_ff <= 12'h000;
        else if (quiet_ff != 12'hFFF)
            quiet_ff <= quiet_ff + 12'h001;
    end
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    // ----------
    // Properties
    // ----------
    a_lockout_off: assert property (PIN_IN.supply_lockout [*3] |=> off)
        else $error("gate on in lockout");
    a_enable_off: assert property (!PIN_IN.enable [*3] |=> off)
        else $error("gate on while disabled");
    a_middle_off: assert property ((!PIN_IN.pwm_above_high && !PIN_IN.pwm_below_low) [*3] |=> off)
        else $error("gate on in middle band");
    a_high_uv_off: assert property (PIN_IN.high_uv [*3] |=> !HIGH_GATE_OUT)
        else $error("high gate on in undervoltage");
    a_low_uv_off: assert property (PIN_IN.low_uv [*3] |=> !LOW_GATE_OUT)
        else $error("low gate on in undervoltage");
    a_thermal_off: assert property (PIN_IN.thermal [*3] |=> off)
        else $error("gate on when hot");
    a_fault_set: assert property (fault_n_out [*3] |=> !FAULT_N_OE_N)
        else $error("fault not driven");
    a_release_time: assert property ($rose(FAULT_N_OE_N) |-> quiet_ff inside {[12'h7CB:12'h7DA]})
        else $error("fault released at wrong time");
    a_release_due: assert property (quiet_ff == 12'h7DA |-> FAULT_N_OE_N)
        else $error("fault not released");
    a_drive_low: assert property (FAULT_N_OUT == 1'b0)
        else $error("fault pin driven high");
    a_no_overlap: assert property (!(HIGH_GATE_OUT && LOW_GATE_OUT))
        else $error("both gates on");
    a_vgs_first: assert property ($rose(HIGH_GATE_OUT) |-> $past(PIN_IN.low_vgs_low, 3))
        else $error("high gate before low side off");
    a_dead_gap: assert property (($fell(LOW_GATE_OUT) || $fell(HIGH_GATE_OUT)) |-> off [*2])
        else $error("no dead-time gap");
    c_high_on: cover property ($rose(HIGH_GATE_OUT));
    c_release: cover property ($rose(FAULT_N_OE_N));
    c_switch: cover property ($fell(LOW_GATE_OUT) ##[1:20] HIGH_GATE_OUT);
endmodule

bind half_bridge_gate_control hb_properties chk_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PIN_IN(PIN_IN),
    .HIGH_GATE_OUT(HIGH_GATE_OUT), .LOW_GATE_OUT(LOW_GATE_OUT), .FAULT_N_OUT(FAULT_N_OUT),
    .FAULT_N_OE_N(FAULT_N_OE_N));

// ===== verif/ctrl_model.sv
// Purpose: Controller and MOSFET stand-in on the far side
// Assumes: Gate-source voltage follows its gate command at once
// Notes:   Fault wire pulled up here
module ctrl_model
(
    input  wire logic [1:0] level,  // 0 low, 1 high, 2 open
    input  wire logic       hold,   // Keep low MOSFET charged
    input  wire logic       hg,     // High gate
    input  wire logic       lg,     // Low gate
    input  wire logic       fo,     // Fault level
    input  wire logic       foe,    // Fault enable, low drives
    output logic            pa,     // Above high threshold
    output logic            pb,     // Below low threshold
    output logic            hv,     // High gate-source low
    output logic            lv,     // Low gate-source low
    output logic            fline   // Fault wire
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pa = level == 2'h1;
    assign pb = level == 2'h0;
    assign fline = foe ? 1'b1 : fo;
    assign hv = !hg;
    assign lv = !lg && !hold;
endmodule

// ===== verif/testbench.sv
// Purpose: Self-checking bench of the gate control block
// Assumes: 20 MHz clock, controller model on the input side
// Notes:   Dead-time judged by differences between settings
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import hb_pkg::*;
    logic        clk, rst_n, hold, en, lock, huv, luv, therm;
    logic        pa, pb, hv, lv, fline, rd, wr, wreq, irq, hg, lg, fo, foe;
    logic [1:0]  level;
    logic [4:0]  addr;
    logic [31:0] wdat, rdat;
    pin_in_type  pin;
    int          bad_count = 0;
    int          compares = 0;
    assign pin = {pa, pb, en, lock, huv, luv, therm, hv, lv};
    half_bridge_gate_control uut (.SYS_CLK(clk), .RST_N(rst_n), .PIN_IN(pin), .HIGH_GATE_OUT(hg),
        .LOW_GATE_OUT(lg), .FAULT_N_OUT(fo), .FAULT_N_OE_N(foe), .IRQ(irq), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(wdat),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq));
    ctrl_model ctrl (.level(level), .hold(hold), .hg(hg), .lg(lg), .fo(fo), .foe(foe),
        .pa(pa), .pb(pb), .hv(hv), .lv(lv), .fline(fline));
    // ----------
    // Helpers
    // ----------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdat <= d;
        @(negedge clk);
        while (wreq !== 1'b0) @(negedge clk);
        @(posedge clk);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    function automatic int dt_n(input logic [31:0] c);
        int r;
        int ps;
        r = c[14:8] > DT_RES_MAX_KOHM ? DT_RES_MAX_KOHM : c[14:8];
        ps = c[1:0] == 2'h1 ? DT_BASE_PS : c[1:0] == 2'h2 ? DT_OPEN_PS : DT_BASE_PS + r * DT_SLOPE_PS_PER_K;
        return (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    endfunction
    task automatic wait_rel(output int n);
        for (n = 0; n < 3000 && fline !== 1'b1; n++) @(posedge clk);
    endtask
    task automatic gap(input logic up, output int g);
        level <= up ? 2'h1 : 2'h0;
        @(negedge clk);
        for (int k = 0; k < 100 && (up ? lg : hg) !== 1'b0; k++) @(negedge clk);
        for (g = 0; g < 100 && (up ? hg : lg) !== 1'b1; g++) @(negedge clk);
        @(posedge clk);
    endtask
    // ----------
    // Scenarios
    // ----------
    task automatic t_reset();
        logic [31:0] q;
        @(negedge clk);
        chk("gates", {hg, lg}, 0);
        chk("fault enable", foe, 0);
        @(posedge clk);
        bus(0, ADDR_DT_CFG, 0, q);
        chk("dt config", q, 32'h2);
        bus(0, ADDR_DT_CYCLES, 0, q);
        chk("dt cycles", q, dt_n(32'h2));
        bus(1, 5'h14, 32'hFFFF, q);
        bus(0, 5'h14, 0, q);
        chk("unmapped", q, 0);
        bus(0, ADDR_IRQ_MASK, 0, q);
        chk("irq mask", q, 0);
        $display("reset test done");
    endtask
    task automatic t_release();
        int n;
        wait_rel(n);
        chk("released", fline, 1);
        lock <= 1'b1;
        repeat (4) @(posedge clk);
        chk("fault line", fline, 0);
        lock <= 1'b0;
        wait_rel(n);
        chk("release time", n inside {[1998:2006]}, 1);
        huv <= 1'b1;
        @(posedge clk);
        huv <= 1'b0;
        repeat (1000) @(posedge clk);
        luv <= 1'b1;
        @(posedge clk);
        luv <= 1'b0;
        wait_rel(n);
        chk("restart time", n inside {[1998:2006]}, 1);
        $display("fault test done");
    endtask
    task automatic t_table();
        logic [5:0] x;
        for (int i = 0; i < 48; i++)
        begin
            x = i[5:0];
            {en, lock, huv, luv} <= x[3:0];
            level <= x[5:4];
            repeat (16) @(posedge clk);
            chk("high gate", hg, x[3] & !x[2] & (x[5:4] == 2'h1) & !x[1]);
            chk("low gate", lg, x[3] & !x[2] & (x[5:4] == 2'h0) & !x[0]);
        end
        {en, lock, huv, luv} <= 4'h8;
        $display("table test done");
    endtask
    task automatic t_dead();
        logic [31:0] cfg [6] = '{32'h1, 32'h2, 32'h6300, 32'h2800, 32'h2900, 32'h7F00};
        logic [31:0] q;
        int g0, g1, g2;
        for (int i = 0; i < 6; i++)
        begin
            bus(1, ADDR_DT_CFG, cfg[i], q);
            bus(0, ADDR_DT_CYCLES, 0, q);
            chk("dt cycles", q, dt_n(cfg[i]));
            level <= 2'h1;
            repeat (20) @(posedge clk);
            gap(1'b0, g1);
            gap(1'b1, g2);
            if (i == 0)
                g0 = g1;
            chk("gap symmetry", g1, g2);
            chk("gap length", g1 - g0, dt_n(cfg[i]) - dt_n(cfg[0]));
        end
        $display("dead-time test done");
    endtask
    task automatic t_lock();
        level <= 2'h2;
        repeat (12) @(posedge clk);
        hold <= 1'b1;
        level <= 2'h1;
        repeat (40) @(posedge clk);
        chk("high gate held", hg, 0);
        hold <= 1'b0;
        repeat (20) @(posedge clk);
        chk("high gate freed", hg, 1);
        $display("interlock test done");
    endtask
    task automatic t_thermal();
        logic [31:0] q;
        bus(1, ADDR_IRQ_STATUS, 32'h7, q);
        bus(1, ADDR_IRQ_MASK, 32'h4, q);
        chk("irq idle", irq, 0);
        therm <= 1'b1;
        repeat (20) @(posedge clk);
        chk("gates hot", {hg, lg}, 0);
        chk("irq raised", irq, 1);
        bus(0, ADDR_IRQ_STATUS, 0, q);
        chk("thermal event", q[2], 1);
        bus(1, ADDR_IRQ_STATUS, 32'h4, q);
        repeat (2) @(posedge clk);
        chk("irq cleared", irq, 0);
        therm <= 1'b0;
        repeat (20) @(posedge clk);
        chk("gates cool", hg, 1);
        bus(1, ADDR_IRQ_MASK, 0, q);
        therm <= 1'b1;
        repeat (6) @(posedge clk);
        chk("irq masked", irq, 0);
        bus(0, ADDR_IRQ_STATUS, 0, q);
        chk("masked event", q[2], 1);
        therm <= 1'b0;
        $display("thermal test done");
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ----------
    // Sequence
    // ----------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
    initial
    begin
        {rst_n, hold, en, lock, huv, luv, therm, rd, wr, addr, wdat} = '0;
        level = 2'h2;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_release();
        t_table();
        t_dead();
        t_lock();
        t_thermal();
        give_verdict();
    end
endmodule
